/* File: common/sadc_pkg.sv */
// sadc_pkg: register map, field positions, reset values and timing counts
// assumes a 32-bit AHB-Lite register bus, one word per register
package sadc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_CONTROL_THREE = 8'h08;
  localparam logic [7:0] OFF_CONTROL_FOUR = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_SAMPLE_IN = 8'h14;
  localparam logic [7:0] OFF_RESULT_BASE = 8'h40;
  // ---------------------------------------------------------------
  // control one fields
  // ---------------------------------------------------------------
  localparam int ON_BIT = 15;
  localparam int ORDER_BIT = 12;
  localparam int RES_BIT = 10;
  localparam int FILL_HI = 9;
  localparam int FILL_LO = 8;
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 5;
  localparam int AUTO_BIT = 3;
  localparam int START_BIT = 1;
  localparam int OUTPUT_FORMAT_HI = 12 - 11;
  localparam int OUTPUT_FORMAT_SHIFT = 13;
  // ---------------------------------------------------------------
  // control two fields
  // ---------------------------------------------------------------
  localparam int VREF_HI = 15;
  localparam int VREF_LO = 13;
  localparam int CHCNT_HI = 9;
  localparam int CHCNT_LO = 8;
  localparam int SIM_BIT = 7;
  localparam int RATE_HI = 5;
  localparam int RATE_LO = 2;
  // ---------------------------------------------------------------
  // control three fields
  // ---------------------------------------------------------------
  localparam int CLKSRC_BIT = 15;
  localparam int AUTO_SAMPLE_TIME_HI = 12;
  localparam int AUTO_SAMPLE_TIME_LO = 8;
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 0;
  // ---------------------------------------------------------------
  // control four fields
  // ---------------------------------------------------------------
  localparam int BLEN_HI = 2;
  localparam int BLEN_LO = 0;
  // ---------------------------------------------------------------
  // encodings, reset values, timing
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_INTERNAL = 3'h7;
  localparam logic [1:0] CHCNT_TWO = 2'h1;
  localparam logic [1:0] OUTPUT_FORMAT_Q15 = 2'h3;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam int CONV_TADS_10 = 12;
  localparam int CONV_TADS_12 = 14;
  localparam int RESULT_WORDS = 16;
  localparam int RC_DIV = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } sadc_state_type;
endpackage

/* File: rtl/sadc_tad_gen.sv */
// sadc_tad_gen: conversion clock enable from the instruction clock or rc tick
// assumes one hclk domain; rc tick is a one-cycle enable
`timescale 1ns/100ps
module sadc_tad_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic use_rc,
  input wire logic rc_tick,
  input wire logic [7:0] divider,
  output logic tad_tick
);
  logic [7:0] count;
  logic step;

  // ---------------------------------------------------------------
  // divider: one tick every divider+1 source steps
  // ---------------------------------------------------------------
  assign step = use_rc ? rc_tick : 1'b1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      tad_tick <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      tad_tick <= 1'b0;
    end else if (step) begin
      tad_tick <= (count == divider);
      count <= (count == divider) ? 8'h00 : count + 8'h01;
    end else begin
      tad_tick <= 1'b0;
    end
  end

  chk_tad_rate_sys: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !use_rc && divider == 8'h02 && $past(run, 4) && $stable(divider) && tad_tick)
      |=> !tad_tick ##1 !tad_tick ##1 (tad_tick || !run)) else $error("tad period wrong");
endmodule

/* File: rtl/sadc_sequencer.sv */
// sadc_sequencer: sample/convert sequencer with result buffer and dma order port
// assumes an ahb-lite master, a dma controller taking dma_req pulses,
// and an analog core whose digitised sample is presented on sample_in
// Functional notes
// - order bit set: results go to dma in conversion order
// - no per-input blocks; results go in conversion order whatever the fill mode
// - dma address advances one word per delivered result
// - software keeps increment rate zero; block length field ignored
// - resolution bit clear selects 10-bit, set selects 12-bit
// - auto-sample restarts sampling right after each conversion
// - source 111: sample counter ends sampling, starts conversion
// - clock source bit 0 uses instruction clock, not rc
// - conversion clock period is cycle times divider plus one
// - 10-bit conversion lasts exactly 12 conversion clock periods
// - channel count 01, not simultaneous: two holds in sequence
// - 16-word result buffer; half status shows filling half
// - auto-sample bit starts sampling; trigger ends it, starts conversion
// - format 3 gives signed fractional q15 results
// - vref 15:13, channel count 9:8 of two; fill mode 9:8 of one
// - dma request raised when conversion-complete flag sets
// - dma address equals the stand-alone result buffer address
// - dma pointer resets to zero when module is switched on
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module sadc_sequencer #(
  parameter int WORDS = sadc_pkg::RESULT_WORDS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic conv_trigger,
  input wire logic rc_tick,
  output logic hold_sel,
  output logic sampling,
  output logic conv_done_flag,
  output logic dma_req,
  output logic [3:0] dma_addr,
  output logic [15:0] dma_data
);
  logic [15:0] control_one, control_two, control_three, control_four;
  logic [11:0] sample_reg;
  logic [15:0] result_buf [WORDS];
  logic [3:0] wr_ptr;
  logic [4:0] tad_count, auto_sample_time_count;
  logic hold_idx;
  logic buffer_half_status;
  logic module_on, was_on;
  logic tad_tick;
  logic ap_write, ap_read;
  logic [7:0] ap_addr;
  sadc_pkg::sadc_state_type state, next_state;
  logic [4:0] conv_len;
  logic conv_end, samp_end;
  logic [3:0] last_dma_addr;
  logic last_dma_valid;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  assign module_on = control_one[sadc_pkg::ON_BIT];
  assign conv_len = control_one[sadc_pkg::RES_BIT] ? 5'(sadc_pkg::CONV_TADS_12)
                                                  : 5'(sadc_pkg::CONV_TADS_10);
  assign conv_end = (state == sadc_pkg::ST_CONVERT) && tad_tick
                    && (tad_count == conv_len - 5'h01);
  assign samp_end = (state == sadc_pkg::ST_SAMPLE) &&
    ((control_one[sadc_pkg::SRC_HI:sadc_pkg::SRC_LO] == sadc_pkg::SRC_INTERNAL)
      ? (tad_tick && auto_sample_time_count >= control_three[sadc_pkg::AUTO_SAMPLE_TIME_HI:sadc_pkg::AUTO_SAMPLE_TIME_LO])
      : conv_trigger);

  function automatic logic [15:0] fmt(input logic [1:0] output_format, input logic [11:0] raw,
                                      input logic wide);
    logic [11:0] v;
    v = wide ? raw : {2'h0, raw[9:0]};
    case (output_format)
      sadc_pkg::OUTPUT_FORMAT_Q15: fmt = wide ? {~v[11], v[10:0], 4'h0}
                                     : {~v[9], v[8:0], 6'h00};
      2'h1: fmt = wide ? {{4{~v[11]}}, ~v[11], v[10:0]} : {{6{~v[9]}}, ~v[9], v[8:0]};
      2'h2: fmt = wide ? {v[11:0], 4'h0} : {v[9:0], 6'h00};
      default: fmt = {4'h0, v};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write <= 1'b0;
      ap_read <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_write <= hsel && htrans[1] && hwrite;
      ap_read <= hsel && htrans[1] && !hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_one <= sadc_pkg::CONTROL_RESET;
      control_two <= sadc_pkg::CONTROL_RESET;
      control_three <= sadc_pkg::CONTROL_RESET;
      control_four <= sadc_pkg::CONTROL_RESET;
      sample_reg <= 12'h000;
    end else if (ap_write) begin
      case (ap_addr)
        sadc_pkg::OFF_CONTROL_ONE: control_one <= hwdata[15:0];
        sadc_pkg::OFF_CONTROL_TWO: control_two <= hwdata[15:0];
        sadc_pkg::OFF_CONTROL_THREE: control_three <= hwdata[15:0];
        sadc_pkg::OFF_CONTROL_FOUR: control_four <= hwdata[15:0];
        sadc_pkg::OFF_SAMPLE_IN: sample_reg <= hwdata[11:0];
        default: sample_reg <= sample_reg;
      endcase
    end
  end

  // read data registered from the address phase so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        sadc_pkg::OFF_CONTROL_ONE: hrdata <= {16'h0000, control_one};
        sadc_pkg::OFF_CONTROL_TWO: hrdata <= {16'h0000, control_two};
        sadc_pkg::OFF_CONTROL_THREE: hrdata <= {16'h0000, control_three};
        sadc_pkg::OFF_CONTROL_FOUR: hrdata <= {16'h0000, control_four};
        sadc_pkg::OFF_STATUS: hrdata <= {24'h0, 3'h0, state, hold_idx, buffer_half_status};
        sadc_pkg::OFF_SAMPLE_IN: hrdata <= {20'h0, sample_reg};
        default: begin
          if (haddr[7:6] == sadc_pkg::OFF_RESULT_BASE[7:6]) begin
            hrdata <= {16'h0000, result_buf[haddr[5:2]]};
          end else begin
            hrdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------
  sadc_tad_gen u_tad (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(module_on),
    .use_rc(control_three[sadc_pkg::CLKSRC_BIT]),
    .rc_tick(rc_tick),
    .divider(control_three[sadc_pkg::DIV_HI:sadc_pkg::DIV_LO]),
    .tad_tick(tad_tick)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      sadc_pkg::ST_IDLE: begin
        if (control_one[sadc_pkg::AUTO_BIT] || control_one[sadc_pkg::START_BIT]) begin
          next_state = sadc_pkg::ST_SAMPLE;
        end
      end
      sadc_pkg::ST_SAMPLE: begin
        if (samp_end) begin
          next_state = sadc_pkg::ST_CONVERT;
        end
      end
      sadc_pkg::ST_CONVERT: begin
        if (conv_end) begin
          next_state = control_one[sadc_pkg::AUTO_BIT] ? sadc_pkg::ST_SAMPLE
                                                      : sadc_pkg::ST_IDLE;
        end
      end
      default: next_state = sadc_pkg::ST_IDLE;
    endcase
    if (!module_on) begin
      next_state = sadc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= sadc_pkg::ST_IDLE;
      sampling <= 1'b0;
    end else begin
      state <= next_state;
      sampling <= (next_state == sadc_pkg::ST_SAMPLE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tad_count <= 5'h00;
      auto_sample_time_count <= 5'h00;
    end else if (state != next_state) begin
      tad_count <= 5'h00;
      auto_sample_time_count <= 5'h00;
    end else if (tad_tick) begin
      tad_count <= tad_count + 5'h01;
      auto_sample_time_count <= auto_sample_time_count + 5'h01;
    end
  end

  // two hold channels in turn when count is 01 and not simultaneous
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_idx <= 1'b0;
      hold_sel <= 1'b0;
    end else begin
      if (!module_on) begin
        hold_idx <= 1'b0;
      end else if (conv_end) begin
        hold_idx <= (control_two[sadc_pkg::CHCNT_HI:sadc_pkg::CHCNT_LO] == sadc_pkg::CHCNT_TWO)
                    && !control_two[sadc_pkg::SIM_BIT] && !hold_idx;
      end
      hold_sel <= hold_idx;
    end
  end

  // ---------------------------------------------------------------
  // result buffer, dma port
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 4'h0;
      was_on <= 1'b0;
      buffer_half_status <= 1'b0;
    end else begin
      was_on <= module_on;
      if (module_on && !was_on) begin
        wr_ptr <= 4'h0;
        buffer_half_status <= 1'b0;
      end else if (conv_end) begin
        // one word per result, no per-input blocks, block length ignored
        wr_ptr <= wr_ptr + 4'h1;
        if (control_one[sadc_pkg::FILL_LO] && wr_ptr[2:0] == 3'h7) begin
          buffer_half_status <= ~wr_ptr[3];
        end
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (conv_end) begin
      result_buf[wr_ptr] <= fmt(control_one[sadc_pkg::OUTPUT_FORMAT_SHIFT+1:sadc_pkg::OUTPUT_FORMAT_SHIFT],
                                sample_reg, control_one[sadc_pkg::RES_BIT]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_req <= 1'b0;
      conv_done_flag <= 1'b0;
      dma_addr <= 4'h0;
      dma_data <= 16'h0000;
    end else begin
      dma_req <= conv_end && control_one[sadc_pkg::ORDER_BIT];
      conv_done_flag <= conv_end;
      if (conv_end) begin
        dma_addr <= wr_ptr;
        dma_data <= fmt(control_one[sadc_pkg::OUTPUT_FORMAT_SHIFT+1:sadc_pkg::OUTPUT_FORMAT_SHIFT],
                        sample_reg, control_one[sadc_pkg::RES_BIT]);
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // last delivered dma address, forgotten while off or out of order mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_dma_addr <= 4'h0;
      last_dma_valid <= 1'b0;
    end else if (!module_on || !control_one[sadc_pkg::ORDER_BIT]) begin
      last_dma_valid <= 1'b0;
    end else if (dma_req) begin
      last_dma_addr <= dma_addr;
      last_dma_valid <= 1'b1;
    end
  end

  chk_dma_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
    dma_req |=> !dma_req) else $error("dma request longer than one cycle");
  chk_dma_addr_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (dma_req && last_dma_valid) |-> dma_addr == last_dma_addr + 4'h1)
    else $error("dma address skipped");
  chk_req_on_done: assert property (@(posedge hclk) disable iff (!hresetn)
    (conv_end && control_one[sadc_pkg::ORDER_BIT]) |=> dma_req && conv_done_flag)
    else $error("no dma request on completion");
  chk_ptr_reset_on: assert property (@(posedge hclk) disable iff (!hresetn)
    (module_on && !was_on) |=> wr_ptr == 4'h0) else $error("pointer not cleared");
  chk_auto_resample: assert property (@(posedge hclk) disable iff (!hresetn)
    (conv_end && control_one[sadc_pkg::AUTO_BIT] && module_on) |=> state == sadc_pkg::ST_SAMPLE)
    else $error("auto sampling did not restart");
  chk_conv_len_ten: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_end && !control_one[sadc_pkg::RES_BIT] |-> tad_count == 5'd11)
    else $error("10-bit conversion not 12 periods");
  chk_internal_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == sadc_pkg::ST_SAMPLE && samp_end && module_on &&
     control_one[sadc_pkg::SRC_HI:sadc_pkg::SRC_LO] == sadc_pkg::SRC_INTERNAL)
      |=> state == sadc_pkg::ST_CONVERT) else $error("sample counter did not start conversion");
  chk_hold_alternate: assert property (@(posedge hclk) disable iff (!hresetn)
    (conv_end && module_on && !hold_idx && !control_two[sadc_pkg::SIM_BIT] &&
     control_two[sadc_pkg::CHCNT_HI:sadc_pkg::CHCNT_LO] == sadc_pkg::CHCNT_TWO) |=> hold_idx)
    else $error("second hold channel skipped");
  chk_half_flip: assert property (@(posedge hclk) disable iff (!hresetn)
    (conv_end && control_one[sadc_pkg::FILL_LO] && wr_ptr == 4'h7) |=> buffer_half_status)
    else $error("buffer half status did not flip");
  chk_rc_gates_tad: assert property (@(posedge hclk) disable iff (!hresetn)
    (control_three[sadc_pkg::CLKSRC_BIT] && !rc_tick)
      |=> !tad_tick)
    else $error("conversion clock ran without rc step");
  cov_order_dma: cover property (@(posedge hclk) dma_req);
  cov_auto_loop: cover property (@(posedge hclk) conv_end && control_one[sadc_pkg::AUTO_BIT]);
  cov_half_flip: cover property (@(posedge hclk) $rose(buffer_half_status));
  cov_rc_clock: cover property (@(posedge hclk) tad_tick && control_three[sadc_pkg::CLKSRC_BIT]);
endmodule

/* File: test/sadc_dma_sink.sv */
// sadc_dma_sink: dma controller model taking results in conversion order
// assumes dma_req is a one-cycle pulse on hclk and clear is driven by the bench
`timescale 1ns/100ps
module sadc_dma_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic dma_req,
  input wire logic [3:0] dma_addr,
  input wire logic [15:0] dma_data,
  output int count,
  output int step_errs,
  output logic [3:0] first_addr,
  output logic [3:0] last_addr,
  output logic [15:0] last_data
);
  // ---------------------------------------------------------------
  // transfer capture, register-indirect: stored in arrival order
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 0;
      step_errs <= 0;
      first_addr <= 4'h0;
      last_addr <= 4'h0;
      last_data <= 16'h0000;
    end else if (clear) begin
      count <= 0;
      step_errs <= 0;
    end else if (dma_req === 1'b1) begin
      if (count == 0) first_addr <= dma_addr;
      if (count > 0 && dma_addr !== last_addr + 4'h1) step_errs <= step_errs + 1;
      count <= count + 1;
      last_addr <= dma_addr;
      last_data <= dma_data;
    end
  end
endmodule

/* File: test/test_sar_adc_sequencer_dma_order.sv */
// test_sar_adc_sequencer_dma_order: self-checking bench for the sequencer
// assumes zero-wait ahb-lite slave and the dma sink model beside it
`timescale 1ns/100ps
module test_sar_adc_sequencer_dma_order;
  logic hclk, hresetn, hsel, hwrite, hready, conv_trigger, rc_tick, clear, rc_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, hold_sel, sampling, conv_done_flag, dma_req, prev_hold, prev_req;
  logic [3:0] dma_addr, first_addr, last_addr;
  logic [15:0] dma_data, last_data;
  int count, step_errs, bad_count, tests_run, cyc, dones, prev_cyc, period, alt_errs, pulse_errs;
  int pa;
  int rows [4][6] = '{'{1, 0, 1, 0, 3, 2}, '{3, 0, 1, 1, 1, 2}, '{0, 0, 2, 0, 5, 3},
                      '{2, 0, 2, 1, 2, 2}};
  assign hready = hreadyout;
  sadc_sequencer sadc_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_trigger(conv_trigger),
    .rc_tick(rc_tick), .hold_sel(hold_sel), .sampling(sampling),
    .conv_done_flag(conv_done_flag), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_data(dma_data));
  sadc_dma_sink sadc_dma_sink_i (.hclk(hclk), .hresetn(hresetn), .clear(clear),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data), .count(count),
    .step_errs(step_errs), .first_addr(first_addr), .last_addr(last_addr),
    .last_data(last_data));
  // ---------------------------------------------------------------
  // clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    prev_req <= dma_req;
    rc_tick <= rc_en && (cyc % 3 == 0);
    if (dma_req === 1'b1 && prev_req === 1'b1) pulse_errs <= pulse_errs + 1;
    if (conv_done_flag === 1'b1) begin
      if (dones > 0 && hold_sel === prev_hold) alt_errs <= alt_errs + 1;
      dones <= dones + 1;
      period <= cyc - prev_cyc;
      prev_cyc <= cyc;
      prev_hold <= hold_sel;
    end
  end
  initial begin
    repeat (90000) @(posedge hclk);
    bad_count = bad_count + 1;
    summarize();
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
      bad_count = bad_count + 1;
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [15:0] c1(input logic [1:0] fmt, input logic res,
                                     input logic fill, input logic [2:0] src);
    c1 = 16'h0008;
    c1[sadc_pkg::ON_BIT] = 1'b1;
    c1[sadc_pkg::OUTPUT_FORMAT_SHIFT +: 2] = fmt;
    c1[sadc_pkg::ORDER_BIT] = 1'b1;
    c1[sadc_pkg::RES_BIT] = res;
    c1[sadc_pkg::FILL_LO] = fill;
    c1[sadc_pkg::SRC_HI:sadc_pkg::SRC_LO] = src;
  endfunction
  function automatic logic [15:0] c3(input logic rc, input logic [4:0] auto_sample_time,
                                     input logic [7:0] div);
    c3 = {rc, 2'h0, auto_sample_time, div};
  endfunction
  task automatic start(input logic [15:0] v1, input logic [1:0] chcnt, input logic [15:0] v3);
    bus(sadc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h0);
    bus(sadc_pkg::OFF_CONTROL_TWO, 1'b1, {22'h0, chcnt, 8'h00});
    bus(sadc_pkg::OFF_CONTROL_THREE, 1'b1, {16'h0, v3});
    bus(sadc_pkg::OFF_CONTROL_FOUR, 1'b1, 32'h7);
    clear <= 1'b1;
    @(posedge hclk);
    clear <= 1'b0;
    dones = 0;
    alt_errs = 0;
    bus(sadc_pkg::OFF_CONTROL_ONE, 1'b1, {16'h0, v1});
  endtask
  task automatic wait_done(input int n);
    int t;
    t = 0;
    while (dones < n && t < 20000) begin
      @(posedge hclk);
      t = t + 1;
    end
    @(posedge hclk);
    check("conversions", dones >= n, 1);
    check("dma count", count, dones);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, conv_trigger, rc_tick, clear, rc_en} = 7'h0;
    {haddr, hwdata, htrans, hsize} = '0;
    {bad_count, tests_run, cyc, dones, prev_cyc, period, alt_errs, pulse_errs} = '0;
    {prev_hold, prev_req} = 2'b00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("hreadyout", hreadyout, 1);
    check("idle outputs", {dma_req, sampling, conv_done_flag, hresp}, 0);
    bus(sadc_pkg::OFF_CONTROL_ONE, 1'b0, 32'h0);
    check("control one reset", rd, 0);
    bus(8'h30, 1'b0, 32'h0);
    check("unmapped read", rd, 0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      start(c1(2'h0, rows[i][1][0], 1'b0, 3'h7), 2'h0, c3(1'b0, rows[i][2], rows[i][0]));
      wait_done(3);
      pa = period;
      check("first dma word", first_addr, 0);
      start(c1(2'h0, rows[i][3][0], 1'b0, 3'h7), 2'h0, c3(1'b0, rows[i][4], rows[i][0]));
      wait_done(3);
      check("period delta", period - pa, rows[i][5] * (rows[i][0] + 1));
      check("dma step", step_errs, 0);
      $display("test timing row %0d done", i);
    end
    start(c1(2'h0, 1'b0, 1'b0, 3'h7), sadc_pkg::CHCNT_TWO, c3(1'b0, 5'h2, 8'h1));
    wait_done(6);
    check("hold alternation", alt_errs, 0);
    $display("test two holds done");
    bus(sadc_pkg::OFF_SAMPLE_IN, 1'b1, 32'h0c00);
    for (int f = 0; f < 4; f = f + 3) begin
      start(c1(f[1:0], 1'b1, 1'b0, 3'h7), 2'h0, c3(1'b0, 5'h2, 8'h1));
      wait_done(3);
      check("formatted data", last_data, (f == 3) ? 32'h4000 : 32'h0c00);
      bus(sadc_pkg::OFF_RESULT_BASE, 1'b0, 32'h0);
      check("result buffer", rd[15:0], last_data);
    end
    $display("test formats done");
    start(c1(2'h0, 1'b0, 1'b1, 3'h7), 2'h0, c3(1'b0, 5'h2, 8'h7));
    wait_done(8);
    bus(sadc_pkg::OFF_STATUS, 1'b0, 32'h0);
    check("half after 8", rd[0], 1);
    wait_done(16);
    bus(sadc_pkg::OFF_STATUS, 1'b0, 32'h0);
    check("half after 16", rd[0], 0);
    $display("test buffer halves done");
    start(c1(2'h0, 1'b0, 1'b0, 3'h0), 2'h0, c3(1'b0, 5'h2, 8'h1));
    repeat (60) @(posedge hclk);
    check("waits for trigger", dones, 0);
    check("sampling held", sampling, 1);
    conv_trigger <= 1'b1;
    @(posedge hclk);
    conv_trigger <= 1'b0;
    wait_done(1);
    $display("test trigger done");
    start(c1(2'h0, 1'b0, 1'b0, 3'h7), 2'h0, c3(1'b1, 5'h2, 8'h0));
    repeat (200) @(posedge hclk);
    check("rc idle", dones, 0);
    rc_en <= 1'b1;
    wait_done(2);
    check("single pulse", pulse_errs, 0);
    $display("test rc clock done");
    hresetn <= 1'b0;
    @(posedge hclk);
    check("reset outputs", {dma_req, sampling, conv_done_flag, hold_sel, dma_addr, dma_data}, 0);
    check("ready after reset", hreadyout, 1);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(sadc_pkg::OFF_CONTROL_ONE, 1'b0, 32'h0);
    check("control one after reset", rd, 0);
    $display("test mid reset done");
    summarize();
  end
endmodule
